// file: logic/instrument_primary_interface.sv
// Earth-side primary interface: talker/listener port, display latch, keypad, serial link.
// Assumes registers are driven by a local processor port and bus pins are open drain.
//
// The register offsets and the strobed register port were chosen for this implementation.
`include "ipi_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module instrument_primary_interface
    import ipi_pkg::*;
#(
    parameter int POWER_CLEAR_CYCLES = `PWRCLR_CYCLES,
    parameter int SER_BAUD_CYCLES    = `SER_BAUD_CYCLES,
    parameter int KEY_STEP_TICKS     = `KEY_STEP_TICKS
)(
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_ARST_N,
    input  wire logic [3:0] I_REG_ADDR,
    input  wire logic [7:0] I_REG_WDATA,
    input  wire logic       I_REG_WR,
    input  wire logic       I_REG_RD,
    output logic      [7:0] O_REG_RDATA,
    input  wire logic [7:0] I_DIO_N,
    output logic      [7:0] O_DIO_N,
    output logic      [7:0] O_DIO_N_OE,
    input  wire logic       I_DAV_N,
    output logic            O_DAV_N,
    output logic            O_DAV_N_OE,
    input  wire logic       I_NRFD_N,
    output logic            O_NRFD_N,
    output logic            O_NRFD_N_OE,
    input  wire logic       I_NDAC_N,
    output logic            O_NDAC_N,
    output logic            O_NDAC_N_OE,
    input  wire logic       I_ATN_N,
    output logic      [7:0] O_DISPLAY,
    output logic      [3:0] O_KEY_ROW_N,
    input  wire logic [6:0] I_KEY_COL_N,
    output logic            O_PRIMARY_SERIAL_OUT,
    input  wire logic       I_PRIMARY_SERIAL_IN,
    output logic            O_PRIMARY_POWER_CLEAR,
    output logic            O_TEST_GATE_OUT,
    output logic            O_BUS_CTRL_CLOCK_OUT,
    input  wire logic       I_SIGNATURE_TEST_JUMPER,
    input  wire logic       I_SKIP_SELFTEST_JUMPER
);
    initial begin
        if (POWER_CLEAR_CYCLES < 1 || POWER_CLEAR_CYCLES > 16777215 ||
            SER_BAUD_CYCLES < 4 || SER_BAUD_CYCLES > 65535 ||
            KEY_STEP_TICKS < 1 || KEY_STEP_TICKS > 65535) begin
            $error("instrument_primary_interface: parameter out of range");
        end
    end

    // Power clear and the derived processor and bus-controller clocks.
    logic [23:0] pwr_cnt_q;
    logic        pwr_ok_q;
    logic [4:0]  proc_cnt_q;
    logic [6:0]  busclk_cnt_q;
    wire         proc_en  = (proc_cnt_q == 5'(`PROC_DIV - 1));
    wire         pwr_done = (pwr_cnt_q == 24'(POWER_CLEAR_CYCLES - 1));

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pwr_cnt_q    <= 24'h000000;
            pwr_ok_q     <= 1'b0;
            proc_cnt_q   <= 5'h00;
            busclk_cnt_q <= 7'h00;
        end else begin
            if (!pwr_ok_q) begin
                pwr_cnt_q <= pwr_cnt_q + 24'h000001;
                pwr_ok_q  <= pwr_done;
            end
            proc_cnt_q   <= proc_en ? 5'h00 : proc_cnt_q + 5'h01;
            busclk_cnt_q <= (busclk_cnt_q == 7'(`BUSCLK_DIV - 1)) ? 7'h00 : busclk_cnt_q + 7'h01;
        end
    end
    assign O_PRIMARY_POWER_CLEAR = pwr_ok_q;
    assign O_BUS_CTRL_CLOCK_OUT  = (busclk_cnt_q < 7'(`BUSCLK_DIV / 2));

    // Jumper modes, caught once as power clear releases.
    logic sig_mode_q;
    logic skip_test_q;
    logic gate_req_q;
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sig_mode_q  <= 1'b0;
            skip_test_q <= 1'b0;
        end else if (!pwr_ok_q && pwr_done) begin
            sig_mode_q  <= I_SIGNATURE_TEST_JUMPER;
            skip_test_q <= I_SKIP_SELFTEST_JUMPER;
        end
    end
    // The gate is the probe point of the normal position and also resets the bus controller.
    wire test_gate = !pwr_ok_q || sig_mode_q || gate_req_q;
    assign O_TEST_GATE_OUT = test_gate;

    // Register decode.
    wire wr_data = I_REG_WR && (I_REG_ADDR == `REG_BUS_DATA);
    wire wr_addr = I_REG_WR && (I_REG_ADDR == `REG_BUS_ADDR);
    wire wr_disp = I_REG_WR && (I_REG_ADDR == `REG_DISPLAY);
    wire wr_ser  = I_REG_WR && (I_REG_ADDR == `REG_SER_DATA);
    wire wr_ctrl = I_REG_WR && (I_REG_ADDR == `REG_CTRL);
    wire rd_data = I_REG_RD && (I_REG_ADDR == `REG_BUS_DATA);
    wire rd_key  = I_REG_RD && (I_REG_ADDR == `REG_KEY);
    wire rd_ser  = I_REG_RD && (I_REG_ADDR == `REG_SER_DATA);

    // Talker/listener handshake. Bus lines are true when low.
    src_state_t sh_q;
    acc_state_t ah_q;
    logic [4:0] addr_q;
    logic       listen_q;
    logic       talk_q;
    logic [7:0] rx_q;
    logic       rx_full_q;
    logic [7:0] tx_q;
    logic       tx_full_q;
    wire        atn      = !I_ATN_N;
    wire        dav      = !I_DAV_N;
    wire [7:0]  bus_byte = ~I_DIO_N;
    wire        accepts  = !test_gate && (atn || listen_q);
    wire        acc_rdy  = atn || !rx_full_q;
    wire        take     = accepts && (ah_q == AH_READY) && acc_rdy && dav;
    wire        is_lst   = (bus_byte[7:5] == `CMD_LISTEN_BASE);
    wire        is_tlk   = (bus_byte[7:5] == `CMD_TALK_BASE);
    wire        own_adr  = (bus_byte[4:0] == addr_q);
    wire        rx_set   = take && !atn;
    wire        tx_done  = (sh_q == SH_DAV) && I_NDAC_N;

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ah_q     <= AH_READY;
            listen_q <= 1'b0;
            talk_q   <= 1'b0;
        end else if (test_gate) begin
            ah_q     <= AH_READY;
            listen_q <= 1'b0;
            talk_q   <= 1'b0;
        end else if (take) begin
            ah_q <= AH_HOLD;
            if (atn) begin
                // Addressing moves only roles; nothing here reaches addr_q.
                if (is_lst && own_adr) listen_q <= 1'b1;
                if (bus_byte == `CMD_UNLISTEN) listen_q <= 1'b0;
                if (is_tlk) talk_q <= own_adr;
                if (bus_byte == `CMD_UNTALK) talk_q <= 1'b0;
            end
        end else if (!dav || !accepts) begin
            ah_q <= AH_READY;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sh_q <= SH_IDLE;
        end else if (test_gate || atn || !talk_q) begin
            sh_q <= SH_IDLE;
        end else begin
            unique case (sh_q)
                SH_IDLE:     if (tx_full_q) sh_q <= SH_WAIT_RFD;
                SH_WAIT_RFD: if (I_NRFD_N) sh_q <= SH_DAV;
                SH_DAV:      if (I_NDAC_N) sh_q <= SH_IDLE;
                default:     sh_q <= SH_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rx_q      <= 8'h00;
            rx_full_q <= 1'b0;
            tx_q      <= 8'h00;
            tx_full_q <= 1'b0;
            addr_q    <= `ADDR_RESET;
        end else begin
            if (rx_set) rx_q <= bus_byte;
            rx_full_q <= rx_set || (rx_full_q && !rd_data);
            if (wr_data && !tx_full_q) tx_q <= I_REG_WDATA;
            tx_full_q <= (wr_data || tx_full_q) && !tx_done;
            // Only the local processor, after reading the secondary's stored value
            // or a keypad entry, writes the address; out-of-range values are dropped.
            if (wr_addr && I_REG_WDATA <= 8'(`ADDR_MAX)) addr_q <= I_REG_WDATA[4:0];
        end
    end

    assign O_DIO_N     = 8'h00;
    assign O_DIO_N_OE  = (sh_q != SH_IDLE) ? tx_q : 8'h00;
    assign O_DAV_N     = 1'b0;
    assign O_DAV_N_OE  = (sh_q == SH_DAV);
    assign O_NRFD_N    = 1'b0;
    assign O_NRFD_N_OE = accepts && ((ah_q == AH_HOLD) || !acc_rdy);
    assign O_NDAC_N    = 1'b0;
    assign O_NDAC_N_OE = accepts && (ah_q == AH_READY);

    // Display latch: follows the processor bus during its write strobe, then holds.
    logic [7:0] display_q;
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            display_q <= 8'h00;
            gate_req_q <= 1'b0;
        end else begin
            if (wr_disp) display_q <= I_REG_WDATA;
            if (wr_ctrl) gate_req_q <= I_REG_WDATA[`CTRL_GATE];
        end
    end
    assign O_DISPLAY = display_q;

    // Keypad, stepped from the processor-rate enable.
    keypad_if kp ();
    logic [15:0] key_tick_q;
    logic        key_valid_q;
    key_code_t   key_q;
    wire         key_step = proc_en && (key_tick_q == 16'(KEY_STEP_TICKS - 1));
    assign O_KEY_ROW_N = kp.row_n;
    assign kp.col_n    = I_KEY_COL_N;

    keypad_scan u_scan (
        .i_clk    (I_CORE_CLK),
        .i_arst_n (I_ARST_N),
        .i_step_en(key_step),
        .kp       (kp.scanner)
    );

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            key_tick_q  <= 16'h0000;
            key_valid_q <= 1'b0;
            key_q       <= 5'h00;
        end else begin
            if (proc_en) key_tick_q <= key_step ? 16'h0000 : key_tick_q + 16'h0001;
            if (kp.strobe) key_q <= kp.code;
            key_valid_q <= kp.strobe || (key_valid_q && !rd_key);
        end
    end

    // Serial link to the secondary: 8N1, idle high, held idle during power clear and in signature mode.
    logic [15:0] stx_cnt_q;
    logic [3:0]  stx_bits_q;
    logic [9:0]  stx_sh_q;
    logic [15:0] srx_cnt_q;
    logic [3:0]  srx_bits_q;
    logic [7:0]  srx_sh_q;
    logic [7:0]  srx_q;
    logic        srx_valid_q;
    wire         stx_busy = (stx_bits_q != 4'h0);
    wire         stx_tick = (stx_cnt_q == 16'(SER_BAUD_CYCLES - 1));
    wire         srx_tick = (srx_cnt_q == 16'(SER_BAUD_CYCLES - 1));
    wire         srx_done = srx_tick && (srx_bits_q == 4'h1);
    wire         ser_gate = pwr_ok_q && !sig_mode_q;

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            stx_cnt_q  <= 16'h0000;
            stx_bits_q <= 4'h0;
            stx_sh_q   <= 10'h3FF;
        end else if (!ser_gate) begin
            stx_bits_q <= 4'h0;
            stx_sh_q   <= 10'h3FF;
        end else if (wr_ser && !stx_busy) begin
            stx_sh_q   <= {1'b1, I_REG_WDATA, 1'b0};
            stx_bits_q <= 4'hA;
            stx_cnt_q  <= 16'h0000;
        end else if (stx_busy) begin
            stx_cnt_q <= stx_tick ? 16'h0000 : stx_cnt_q + 16'h0001;
            if (stx_tick) begin
                stx_sh_q   <= {1'b1, stx_sh_q[9:1]};
                stx_bits_q <= stx_bits_q - 4'h1;
            end
        end
    end
    assign O_PRIMARY_SERIAL_OUT = stx_sh_q[0];

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            srx_cnt_q   <= 16'h0000;
            srx_bits_q  <= 4'h0;
            srx_sh_q    <= 8'h00;
            srx_q       <= 8'h00;
            srx_valid_q <= 1'b0;
        end else begin
            if (!ser_gate) begin
                srx_bits_q <= 4'h0;
            end else if (srx_bits_q == 4'h0) begin
                if (!I_PRIMARY_SERIAL_IN) begin
                    // Start half a bit in so data bits are sampled mid-cell.
                    srx_cnt_q  <= 16'(SER_BAUD_CYCLES / 2);
                    srx_bits_q <= 4'h9;
                end
            end else begin
                srx_cnt_q <= srx_tick ? 16'h0000 : srx_cnt_q + 16'h0001;
                if (srx_tick) begin
                    srx_bits_q <= srx_bits_q - 4'h1;
                    srx_sh_q   <= {I_PRIMARY_SERIAL_IN, srx_sh_q[7:1]};
                end
            end
            if (srx_done) srx_q <= {I_PRIMARY_SERIAL_IN, srx_sh_q[7:1]};
            srx_valid_q <= srx_done || (srx_valid_q && !rd_ser);
        end
    end

    // Read data stands in the cycle after the read strobe only.
    wire [7:0] status = {pwr_ok_q, stx_busy, srx_valid_q, key_valid_q,
                         tx_full_q, rx_full_q, talk_q, listen_q};
    wire [7:0] ctrl   = {5'h00, skip_test_q, sig_mode_q, gate_req_q};
    logic [7:0] rd_mux;
    always_comb begin
        unique case (I_REG_ADDR)
            `REG_STATUS:   rd_mux = status;
            `REG_BUS_DATA: rd_mux = rx_q;
            `REG_BUS_ADDR: rd_mux = {3'h0, addr_q};
            `REG_DISPLAY:  rd_mux = display_q;
            `REG_KEY:      rd_mux = {3'h0, key_q};
            `REG_SER_DATA: rd_mux = srx_q;
            `REG_CTRL:     rd_mux = ctrl;
            default:       rd_mux = 8'h00;
        endcase
    end
    logic [7:0] rdata_q;
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= I_REG_RD ? rd_mux : 8'h00;
        end
    end
    assign O_REG_RDATA = rdata_q;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);

    sequence s_byte_taken;
        take && !atn;
    endsequence
    property p_rx_capture;
        s_byte_taken |=> rx_full_q && (rx_q == $past(bus_byte));
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("bus byte not captured");

    property p_unaddressed;
        (!atn && !listen_q) |-> !O_NRFD_N_OE && !O_NDAC_N_OE;
    endproperty
    a_unaddressed: assert property (p_unaddressed) else $error("unaddressed device drives");

    property p_atn_ack;
        (atn && !test_gate && ah_q == AH_READY) |-> O_NDAC_N_OE && !O_NRFD_N_OE;
    endproperty
    a_atn_ack: assert property (p_atn_ack) else $error("attention byte not accepted");

    property p_talk_only;
        O_DAV_N_OE |-> talk_q && !atn && (O_DIO_N_OE == tx_q);
    endproperty
    a_talk_only: assert property (p_talk_only) else $error("source outside talker role");

    property p_addr_range;
        addr_q <= `ADDR_MAX;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("own address out of range");

    property p_display_hold;
        !wr_disp |=> $stable(O_DISPLAY);
    endproperty
    a_display_hold: assert property (p_display_hold) else $error("display changed without write");

    property p_gate_idle;
        test_gate |=> !listen_q && !talk_q && sh_q == SH_IDLE && ah_q == AH_READY;
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("bus controller active in reset");

    property p_pwrclr_quiet;
        !pwr_ok_q |-> O_PRIMARY_SERIAL_OUT && !stx_busy;
    endproperty
    a_pwrclr_quiet: assert property (p_pwrclr_quiet) else $error("serial sent during power clear");

    property p_mode_fixed;
        pwr_ok_q |=> $stable(sig_mode_q) && $stable(skip_test_q);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("jumper mode changed after release");

    property p_busclk_edges;
        $rose(O_BUS_CTRL_CLOCK_OUT) |-> ##(`BUSCLK_DIV / 2) $fell(O_BUS_CTRL_CLOCK_OUT);
    endproperty
    a_busclk_edges: assert property (p_busclk_edges) else $error("bus clock high time wrong");
endmodule
`default_nettype wire

// file: logic/ipi_defines.svh
// Constants for the instrument primary interface: register map, fields, resets and timing.
// Assumes a single 125 MHz core clock; every count below is in those clock cycles, except KEY_STEP_TICKS, which counts processor-rate enables.
`ifndef IPI_DEFINES_SVH
`define IPI_DEFINES_SVH

`define REG_STATUS       4'h0
`define REG_BUS_DATA     4'h1
`define REG_BUS_ADDR     4'h2
`define REG_DISPLAY      4'h3
`define REG_KEY          4'h4
`define REG_SER_DATA     4'h5
`define REG_CTRL         4'h6

`define ST_LISTEN        0
`define ST_TALK          1
`define ST_RX_FULL       2
`define ST_TX_FULL       3
`define ST_KEY_VALID     4
`define ST_SER_RX_VALID  5
`define ST_SER_TX_BUSY   6
`define ST_PWR_OK        7
`define CTRL_GATE        0
`define CTRL_SIG_MODE    1
`define CTRL_SKIP_TEST   2

`define ADDR_RESET       5'h05
`define ADDR_MAX         5'h1E
`define CMD_LISTEN_BASE  3'h1
`define CMD_TALK_BASE    3'h2
`define CMD_UNLISTEN     8'h3F
`define CMD_UNTALK       8'h5F

`define CORE_CLK_HZ      125000000
`define PROC_CLK_HZ      4000000
`define BUSCLK_HZ        1000000
`define PWRCLR_TIME_MS   110
`define SER_BAUD         9600
`define PROC_DIV         (`CORE_CLK_HZ / `PROC_CLK_HZ)
`define BUSCLK_DIV       (`CORE_CLK_HZ / `BUSCLK_HZ)
`define PWRCLR_CYCLES    ((`CORE_CLK_HZ / 1000) * `PWRCLR_TIME_MS)
`define SER_BAUD_CYCLES  (`CORE_CLK_HZ / `SER_BAUD)
`define KEY_STEP_TICKS   4000

`endif

// file: logic/ipi_pkg.sv
// Types shared by the primary interface modules.
// Assumes the constants header is compiled alongside.
package ipi_pkg;
    typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_WAIT_RFD = 2'b01, SH_DAV = 2'b11} src_state_t;
    typedef enum logic {AH_READY = 1'b0, AH_HOLD = 1'b1} acc_state_t;
    typedef logic [4:0] key_code_t;
endpackage

// file: logic/keypad_if.sv
// Carrier between the keypad scanner and the primary interface top.
// Rows are driven low one at a time; columns read low when a key is down.
`timescale 1ns/1ps
`default_nettype none
interface keypad_if;
    import ipi_pkg::*;
    logic [3:0] row_n;
    logic [6:0] col_n;
    key_code_t  code;
    logic       strobe;
    modport scanner (output row_n, input col_n, output code, output strobe);
    modport user    (input row_n, output col_n, input code, input strobe);
endinterface
`default_nettype wire

// file: logic/keypad_scan.sv
// Keypad row/column scanner with two-scan debounce.
// Assumes step_en is a one-cycle pulse; one row is examined per pulse.
`include "ipi_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module keypad_scan
    import ipi_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_step_en,
    keypad_if.scanner       kp
);
    logic [1:0] row_q;
    logic       hit_q;
    key_code_t  hit_code_q;
    logic       prev_hit_q;
    key_code_t  prev_code_q;
    logic       reported_q;
    key_code_t  code_q;
    logic       strobe_q;

    function automatic logic [2:0] first_low(input logic [6:0] c);
        first_low = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (!c[i]) begin
                first_low = 3'(i);
            end
        end
    endfunction

    wire       col_hit   = ~&kp.col_n;
    wire       last_row  = (row_q == 2'h3);
    wire       scan_hit  = hit_q | col_hit;
    wire [4:0] scan_code = hit_q ? hit_code_q : {row_q, first_low(kp.col_n)};
    wire       same_key  = scan_hit && prev_hit_q && (scan_code == prev_code_q);

    assign kp.row_n  = ~(4'h1 << row_q);
    assign kp.code   = code_q;
    assign kp.strobe = strobe_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            row_q       <= 2'h0;
            hit_q       <= 1'b0;
            hit_code_q  <= 5'h00;
            prev_hit_q  <= 1'b0;
            prev_code_q <= 5'h00;
            reported_q  <= 1'b0;
            code_q      <= 5'h00;
            strobe_q    <= 1'b0;
        end else begin
            strobe_q <= 1'b0;
            if (i_step_en) begin
                row_q <= row_q + 2'h1;
                if (last_row) begin
                    hit_q       <= 1'b0;
                    prev_hit_q  <= scan_hit;
                    prev_code_q <= scan_code;
                    // A held key is reported once; release rearms it.
                    reported_q  <= same_key;
                    if (same_key && !reported_q) begin
                        code_q   <= scan_code;
                        strobe_q <= 1'b1;
                    end
                end else if (col_hit && !hit_q) begin
                    hit_q      <= 1'b1;
                    hit_code_q <= {row_q, first_low(kp.col_n)};
                end
            end
        end
    end

    property p_one_row;
        @(posedge i_clk) disable iff (!i_arst_n) $onehot(~kp.row_n);
    endproperty
    a_one_row: assert property (p_one_row) else $error("keypad drives not one row");

    property p_debounce;
        @(posedge i_clk) disable iff (!i_arst_n)
            strobe_q |-> $past(prev_hit_q) && (code_q == $past(prev_code_q));
    endproperty
    a_debounce: assert property (p_debounce) else $error("key reported without match");
endmodule
`default_nettype wire

// file: sim/ipi_bus_ctrl_model.sv
// Behavioural bus controller that sources bytes onto the shared handshake bus.
// Assumes the bench resolves the open-drain lines; released lines float high.
`timescale 1ns/1ps
`default_nettype none
module ipi_bus_ctrl_model (
    input  wire logic       i_clk,
    input  wire logic       i_nrfd_n,
    input  wire logic       i_ndac_n,
    output logic            o_dav_n,
    output logic            o_atn_n,
    output logic      [7:0] o_dio_n
);
    initial begin
        o_dav_n = 1'b1;
        o_atn_n = 1'b1;
        o_dio_n = 8'hFF;
    end
    // A bounded wait stands in for the timeout a real controller keeps.
    task automatic send(input logic atn, input logic [7:0] b);
        int n;
        n = 0;
        @(posedge i_clk);
        o_atn_n <= ~atn;
        o_dio_n <= ~b;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (i_nrfd_n !== 1'b1 && n < 300);
        o_dav_n <= 1'b0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (i_ndac_n !== 1'b1 && n < 600);
        o_dav_n <= 1'b1;
        o_dio_n <= 8'hFF;
        @(posedge i_clk);
        o_atn_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: sim/tb_instrument_primary_interface.sv
// Self-checking bench: registers, bus handshake, latch, keypad, serial loopback.
// Assumes short power-clear, baud and scan counts; serial out is looped back.
`timescale 1ns/1ps
`default_nettype none
module tb_instrument_primary_interface;
    logic       clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, sig = 1'b1, skip = 1'b0;
    logic [3:0] ra = 4'h0, row_n;
    logic [7:0] wd = 8'h00, rq, b, disp, dio_m, dio_oe, tx_seen = 8'h00;
    logic [4:0] a;
    logic [1:0] kr;
    logic [2:0] kc;
    logic       pr = 1'b0, so, pclr, gate, bclk, bq, dav_m, atn_m, dav_oe, nrfd_oe, ndac_oe;
    logic [6:0] col_n;
    int         mismatches = 0, comparisons = 0, seed = 32'h3AC9CFFE, edges = 0;
    assign col_n = (pr && !row_n[kr]) ? ~(7'h01 << kc) : 7'h7F;
    initial forever #4 clk = ~clk;
    // The byte the block sources is what it pulls low while its DAV is asserted.
    always @(posedge clk) if (dav_oe) tx_seen <= dio_oe;
    ipi_bus_ctrl_model i_ipi_bus_ctrl_model (.i_clk(clk), .i_nrfd_n(!nrfd_oe),
        .i_ndac_n(!ndac_oe), .o_dav_n(dav_m), .o_atn_n(atn_m), .o_dio_n(dio_m));
    instrument_primary_interface #(.POWER_CLEAR_CYCLES(50), .SER_BAUD_CYCLES(8),
        .KEY_STEP_TICKS(1)) i_instrument_primary_interface (.I_CORE_CLK(clk),
        .I_ARST_N(arst_n), .I_REG_ADDR(ra), .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd),
        .O_REG_RDATA(rq), .I_DIO_N(dio_m & ~dio_oe), .O_DIO_N(), .O_DIO_N_OE(dio_oe),
        .I_DAV_N(dav_m & !dav_oe), .O_DAV_N(), .O_DAV_N_OE(dav_oe), .I_NRFD_N(!nrfd_oe),
        .O_NRFD_N(), .O_NRFD_N_OE(nrfd_oe), .I_NDAC_N(!ndac_oe), .O_NDAC_N(),
        .O_NDAC_N_OE(ndac_oe), .I_ATN_N(atn_m), .O_DISPLAY(disp), .O_KEY_ROW_N(row_n),
        .I_KEY_COL_N(col_n), .O_PRIMARY_SERIAL_OUT(so), .I_PRIMARY_SERIAL_IN(so),
        .O_PRIMARY_POWER_CLEAR(pclr), .O_TEST_GATE_OUT(gate), .O_BUS_CTRL_CLOCK_OUT(bclk),
        .I_SIGNATURE_TEST_JUMPER(sig), .I_SKIP_SELFTEST_JUMPER(skip));
    task automatic final_report;
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [3:0] x, input logic [7:0] v);
        @(posedge clk);
        ra <= x;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input string n, input logic [3:0] x, input logic [7:0] e);
        @(posedge clk);
        ra <= x;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, e, rq);
    endtask
    task automatic boot(input logic s, input logic k);
        arst_n <= 1'b0;
        sig <= s;
        skip <= k;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (45) @(posedge clk);
        #1 chk("pclr", 8'h00, {7'h00, pclr});
        repeat (10) @(posedge clk);
        #1 chk("pclr", 8'h01, {7'h00, pclr});
    endtask
    initial begin
        boot(1'b1, 1'b0);
        rchk("ctrl", 4'h6, 8'h02);
        sig <= 1'b0;
        rchk("ctrl", 4'h6, 8'h02);
        chk("gate", 8'h01, {7'h00, gate});
        boot(1'b0, 1'b1);
        rchk("ctrl", 4'h6, 8'h04);
        chk("gate", 8'h00, {7'h00, gate});
        wreg(4'h6, 8'h01);
        chk("gate", 8'h01, {7'h00, gate});
        wreg(4'h6, 8'h00);
        rchk("addr", 4'h2, 8'h05);
        wreg(4'h2, 8'h1F);
        rchk("addr", 4'h2, 8'h05);
        a = 5'($unsigned($random(seed)) % 31);
        b = 8'($random(seed));
        wreg(4'h2, {3'h0, a});
        i_ipi_bus_ctrl_model.send(1'b1, {3'h1, a});
        i_ipi_bus_ctrl_model.send(1'b0, b);
        rchk("rx", 4'h1, b);
        rchk("addr", 4'h2, {3'h0, a});
        i_ipi_bus_ctrl_model.send(1'b1, 8'h3F);
        i_ipi_bus_ctrl_model.send(1'b0, ~b);
        rchk("status", 4'h0, 8'h80);
        i_ipi_bus_ctrl_model.send(1'b1, {3'h2, a});
        wreg(4'h1, ~b);
        repeat (8) @(posedge clk);
        #1 chk("talk", ~b, tx_seen);
        i_ipi_bus_ctrl_model.send(1'b1, 8'h5F);
        rchk("status", 4'h0, 8'h80);
        wreg(4'h3, ~b);
        chk("disp", ~b, disp);
        rchk("disp", 4'h3, ~b);
        rchk("unmapped", 4'hF, 8'h00);
        wreg(4'h5, b);
        repeat (120) @(posedge clk);
        rchk("serial", 4'h5, b);
        kr = 2'($random(seed));
        kc = 3'($unsigned($random(seed)) % 7);
        pr <= 1'b1;
        repeat (800) @(posedge clk);
        rchk("key", 4'h4, {3'h0, kr, kc});
        pr <= 1'b0;
        bq = bclk;
        repeat (1250) begin
            @(posedge clk);
            #1 edges += int'(bclk && !bq);
            bq = bclk;
        end
        chk("busclk", 8'h0A, 8'(edges));
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report;
    end
endmodule
`default_nettype wire
